// ### logic/ras_defs.vh
`ifndef RAS_DEFS_VH
`define RAS_DEFS_VH
// Notes on behaviour
// RQ1 - pointer codes 0 to 14 pick entries 0 to 14; code 15 must not be loaded
// RQ2 - power-on, watchdog/stack-fault and chip-enable resets set pointer to all ones
// RQ3 - clock-stop instruction keeps pointer value; it is present on resume
// RQ4 - call, direct or indirect: decrement pointer, then write return address there
// RQ5 - return or return-and-skip: load counter from selected entry, then increment
// RQ6 - table fetch: step pointer down, save return address before the fetch
// RQ7 - table fetch: read program word at address reg to buffer, restore, increment
// RQ8 - interrupt accept: decrement pointer, then store interrupted return address
// RQ9 - interrupt return: restore counter from selected entry, then increment
// RQ10 - push address reg: decrement pointer, then copy address reg into entry
// RQ11 - pop: copy selected entry to address reg, then increment pointer
// RQ12 - system entry: decrement, store return address and segment in entry
// RQ13 - return after system entry: restore counter and segment, then increment
// RQ14 - entry at pointer fifteen is undefined; nesting limited to 15 levels
// RQ15 - software option makes stack overflow or underflow raise a reset to address 0
// RQ16 - each entry holds a full counter value plus the segment value

// register offsets
`define RAS_REG_PTR 4'h0
`define RAS_REG_CTRL 4'h1
`define RAS_REG_STAT 4'h2
`define RAS_REG_MASK 4'h3
// pointer reset value and last entry index
`define RAS_PTR_RESET 4'hf
`define RAS_PTR_LAST 4'he
// status and control bit positions
`define RAS_STAT_OVF 0
`define RAS_STAT_UNF 1
`define RAS_CTRL_FAULT_EN 0
// operation codes
`define RAS_OP_NONE 4'h0
`define RAS_OP_CALL 4'h1
`define RAS_OP_RET 4'h2
`define RAS_OP_TABLE 4'h3
`define RAS_OP_INT 4'h4
`define RAS_OP_INTERRUPT_RETURN_INSTR 4'h5
`define RAS_OP_PUSH 4'h6
`define RAS_OP_POP 4'h7
`define RAS_OP_SYS 4'h8
`define RAS_OP_SYSRET 4'h9
`endif

// ### logic/ras_entry_mem.v
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_entry_mem #(
	parameter AW = 14,
	parameter SW = 4,
	parameter DEPTH = 15
) (
	// clock
	input wire core_clk_i,
	// write port
	input wire wr_en_i,
	input wire [3:0] wr_idx_i,
	input wire [AW+SW-1:0] wr_data_i,
	// read port
	input wire [3:0] rd_idx_i,
	output wire [AW+SW-1:0] rd_data_o
);
	// entries hold counter and segment together [RQ16]
	reg [AW+SW-1:0] slot_mem [0:DEPTH-1];

	always @(posedge core_clk_i) begin
		if (wr_en_i && (wr_idx_i < DEPTH)) begin // [RQ1]
			slot_mem[wr_idx_i] <= wr_data_i;
		end
	end

	// entry fifteen does not exist, reads zero [RQ14]
	assign rd_data_o = (rd_idx_i < DEPTH) ? slot_mem[rd_idx_i] : {(AW+SW){1'b0}};
endmodule

// ### logic/ras_return_address_stack.v
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_return_address_stack #(
	parameter AW = 14,
	parameter SW = 4
) (
	// clock and resets
	input wire core_clk_i,
	input wire resetn_i,
	input wire wdt_reset_i,
	input wire ce_reset_i,
	// sequencer commands
	input wire op_valid_i,
	input wire [3:0] op_code_i,
	input wire [AW-1:0] ret_addr_i,
	input wire [SW-1:0] segment_i,
	input wire [AW-1:0] table_addr_reg_i,
	input wire clock_stop_i,
	// program memory read for table fetch
	input wire [15:0] prog_word_i,
	output wire [AW-1:0] prog_addr_o,
	output wire prog_rd_o,
	// results to the core
	output wire pc_load_o,
	output wire [AW-1:0] pc_value_o,
	output wire seg_load_o,
	output wire [SW-1:0] seg_value_o,
	output wire ar_load_o,
	output wire [AW-1:0] ar_value_o,
	output wire fetch_buffer_load_o,
	output wire [15:0] fetch_buffer_o,
	output wire stack_fault_reset_o,
	// register port
	input wire [3:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [7:0] reg_rdata_o,
	// interrupt
	output wire irq_o
);
	// ******************************
	// state
	// ******************************
	// one-hot: idle, or the fetch cycle of a table read
	localparam ST_IDLE = 2'b01;
	localparam ST_FETCH = 2'b10;

	reg [1:0] state_ff;
	reg [3:0] stack_depth_pointer_ff;
	reg [AW-1:0] prog_addr_ff;
	reg prog_rd_ff;
	reg pc_load_ff;
	reg [AW-1:0] pc_value_ff;
	reg seg_load_ff;
	reg [SW-1:0] seg_value_ff;
	reg ar_load_ff;
	reg [AW-1:0] ar_value_ff;
	reg fb_load_ff;
	reg [15:0] fb_ff;
	reg fault_rst_ff;
	reg fault_en_ff;
	reg [1:0] stat_ff;
	reg [1:0] mask_ff;
	reg irq_ff;
	reg [7:0] rdata_ff;

	wire [3:0] ptr_dec;
	wire [3:0] ptr_inc;
	wire [AW+SW-1:0] slot_rd;
	reg mem_wr;
	reg [AW+SW-1:0] mem_wdata;
	reg is_push;
	reg is_pop;
	reg [1:0] nxt_stat;
	reg [7:0] nxt_rdata;
	wire sync_rst;
	wire cmd_ok;
	wire is_table;
	wire is_ar_pop;
	wire is_seg_pop;
	wire ptr_wr_sel;
	wire ctrl_wr_sel;
	wire stat_wr_sel;
	wire mask_wr_sel;
	wire ptr_wr_ok;
	wire ovf_evt;
	wire unf_evt;

	assign ptr_dec = stack_depth_pointer_ff - 4'h1;
	assign ptr_inc = stack_depth_pointer_ff + 4'h1;

	// ******************************
	// command and register write decode
	// ******************************
	// watchdog/stack-fault and chip-enable resets act alike
	assign sync_rst = wdt_reset_i | ce_reset_i;
	// one command per cycle, dropped while fetching, stopped or in reset
	assign cmd_ok = op_valid_i && (state_ff == ST_IDLE) && !clock_stop_i && !sync_rst;
	assign is_table = is_push && (op_code_i == `RAS_OP_TABLE);
	assign is_ar_pop = is_pop && (op_code_i == `RAS_OP_POP);
	assign is_seg_pop = is_pop && (op_code_i == `RAS_OP_SYSRET);
	assign ptr_wr_sel = reg_wr_i && (reg_addr_i == `RAS_REG_PTR);
	assign ctrl_wr_sel = reg_wr_i && (reg_addr_i == `RAS_REG_CTRL);
	assign stat_wr_sel = reg_wr_i && (reg_addr_i == `RAS_REG_STAT);
	assign mask_wr_sel = reg_wr_i && (reg_addr_i == `RAS_REG_MASK);
	// code fifteen, resets, stop, fetch and a same-cycle command refuse a load [RQ1]
	assign ptr_wr_ok = ptr_wr_sel && (reg_wdata_i[3:0] != `RAS_PTR_RESET) && !sync_rst
		&& !clock_stop_i && (state_ff == ST_IDLE) && !is_push && !is_pop;

	// ******************************
	// stack fault events
	// ******************************
	// push at entry zero wraps to fifteen, pop at fifteen reads nothing [RQ14]
	assign ovf_evt = is_push && (stack_depth_pointer_ff == 4'h0);
	assign unf_evt = is_pop && (stack_depth_pointer_ff == `RAS_PTR_RESET);

	// sticky flags: write one clears, an event in the same cycle wins
	always @* begin
		nxt_stat = stat_ff;
		if (stat_wr_sel) begin
			nxt_stat = nxt_stat & ~reg_wdata_i[1:0];
		end
		if (ovf_evt) begin
			nxt_stat[`RAS_STAT_OVF] = 1'b1;
		end
		if (unf_evt) begin
			nxt_stat[`RAS_STAT_UNF] = 1'b1;
		end
	end

	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stat_ff <= 2'b00;
			fault_rst_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			fault_rst_ff <= fault_en_ff && (ovf_evt || unf_evt); // [RQ15]
		end
	end

	// ******************************
	// command decode
	// ******************************
	always @* begin
		mem_wr = 1'b0;
		mem_wdata = {segment_i, ret_addr_i};
		is_push = 1'b0;
		is_pop = 1'b0;
		if (cmd_ok) begin
			case (op_code_i)
				`RAS_OP_CALL, `RAS_OP_INT, `RAS_OP_TABLE: begin
					mem_wr = 1'b1; // [RQ4] [RQ6] [RQ8]
					is_push = 1'b1;
				end
				`RAS_OP_SYS: begin
					mem_wr = 1'b1; // [RQ12]
					is_push = 1'b1;
				end
				`RAS_OP_PUSH: begin
					mem_wr = 1'b1;
					mem_wdata = {{SW{1'b0}}, table_addr_reg_i}; // [RQ10]
					is_push = 1'b1;
				end
				`RAS_OP_RET, `RAS_OP_INTERRUPT_RETURN_INSTR, `RAS_OP_POP, `RAS_OP_SYSRET: begin
					is_pop = 1'b1;
				end
				default: begin
					mem_wr = 1'b0;
				end
			endcase
		end
	end

	// write goes to the pointer after decrement
	ras_entry_mem #(
		.AW(AW),
		.SW(SW),
		.DEPTH(15)
	) u_mem (
		.core_clk_i(core_clk_i),
		.wr_en_i(mem_wr),
		.wr_idx_i(ptr_dec),
		.wr_data_i(mem_wdata),
		.rd_idx_i(stack_depth_pointer_ff),
		.rd_data_o(slot_rd)
	);

	// ******************************
	// pointer and sequencer
	// ******************************
	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= ST_IDLE;
			stack_depth_pointer_ff <= `RAS_PTR_RESET; // [RQ2]
			prog_addr_ff <= {AW{1'b0}};
			prog_rd_ff <= 1'b0;
			pc_load_ff <= 1'b0;
			pc_value_ff <= {AW{1'b0}};
			seg_load_ff <= 1'b0;
			seg_value_ff <= {SW{1'b0}};
			ar_load_ff <= 1'b0;
			ar_value_ff <= {AW{1'b0}};
			fb_load_ff <= 1'b0;
			fb_ff <= 16'h0000;
		end else begin
			pc_load_ff <= 1'b0;
			seg_load_ff <= 1'b0;
			ar_load_ff <= 1'b0;
			fb_load_ff <= 1'b0;
			prog_rd_ff <= 1'b0;
			// resets first, then clock stop, then commands
			if (sync_rst) begin
				stack_depth_pointer_ff <= `RAS_PTR_RESET; // [RQ2]
				state_ff <= ST_IDLE;
			end else if (clock_stop_i) begin
				stack_depth_pointer_ff <= stack_depth_pointer_ff; // [RQ3]
			end else begin
				case (state_ff)
					ST_IDLE: begin
						if (is_push) begin
							stack_depth_pointer_ff <= ptr_dec; // [RQ4] [RQ8] [RQ10] [RQ12]
							if (is_table) begin
								state_ff <= ST_FETCH; // [RQ6]
								prog_addr_ff <= table_addr_reg_i;
								prog_rd_ff <= 1'b1;
							end
						end else if (is_pop) begin
							stack_depth_pointer_ff <= ptr_inc; // [RQ5] [RQ9] [RQ11] [RQ13]
							if (is_ar_pop) begin
								ar_load_ff <= 1'b1; // [RQ11]
								ar_value_ff <= slot_rd[AW-1:0];
							end else begin
								pc_load_ff <= 1'b1; // [RQ5] [RQ9]
								pc_value_ff <= slot_rd[AW-1:0];
							end
							if (is_seg_pop) begin
								seg_load_ff <= 1'b1; // [RQ13]
								seg_value_ff <= slot_rd[AW+SW-1:AW];
							end
						end
					end
					ST_FETCH: begin
						// restore the saved entry and bring the pointer back up
						fb_load_ff <= 1'b1; // [RQ7]
						fb_ff <= prog_word_i;
						pc_load_ff <= 1'b1;
						pc_value_ff <= slot_rd[AW-1:0];
						stack_depth_pointer_ff <= ptr_inc;
						state_ff <= ST_IDLE;
					end
					default: begin
						state_ff <= ST_IDLE;
					end
				endcase
			end
			// software pointer load; code fifteen is refused [RQ1]
			if (ptr_wr_ok) begin
				stack_depth_pointer_ff <= reg_wdata_i[3:0];
			end
		end
	end

	// ******************************
	// control and mask registers
	// ******************************
	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fault_en_ff <= 1'b0;
			mask_ff <= 2'b00;
		end else begin
			if (ctrl_wr_sel) begin
				fault_en_ff <= reg_wdata_i[`RAS_CTRL_FAULT_EN];
			end
			if (mask_wr_sel) begin
				mask_ff <= reg_wdata_i[1:0];
			end
		end
	end

	// ******************************
	// interrupt
	// ******************************
	// level output, one flop after the unmasked flag
	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(stat_ff & mask_ff);
		end
	end

	// ******************************
	// register read
	// ******************************
	// data stands only in the cycle after the strobe, zero otherwise
	always @* begin
		nxt_rdata = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`RAS_REG_PTR: begin
					nxt_rdata = {4'h0, stack_depth_pointer_ff};
				end
				`RAS_REG_CTRL: begin
					nxt_rdata = {7'h00, fault_en_ff};
				end
				`RAS_REG_STAT: begin
					nxt_rdata = {6'h00, stat_ff};
				end
				`RAS_REG_MASK: begin
					nxt_rdata = {6'h00, mask_ff};
				end
				default: begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ******************************
	// outputs, straight from flops
	// ******************************
	assign prog_addr_o = prog_addr_ff;
	assign prog_rd_o = prog_rd_ff;
	assign pc_load_o = pc_load_ff;
	assign pc_value_o = pc_value_ff;
	assign seg_load_o = seg_load_ff;
	assign seg_value_o = seg_value_ff;
	assign ar_load_o = ar_load_ff;
	assign ar_value_o = ar_value_ff;
	assign fetch_buffer_load_o = fb_load_ff;
	assign fetch_buffer_o = fb_ff;
	assign stack_fault_reset_o = fault_rst_ff;
	assign reg_rdata_o = rdata_ff;
	assign irq_o = irq_ff;
endmodule

// ### sim/ras_pmem_model.sv
`timescale 1ns/1ns
module ras_pmem_model (
	// fetch port
	input wire [13:0] addr_i,
	output wire [15:0] word_o
);
	// combinational program memory
	assign word_o = {addr_i[1:0], addr_i} ^ 16'h5a3c;
endmodule

// ### sim/ras_return_address_stack_properties.sv
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_checker #(
	parameter AW = 14,
	parameter SW = 4
) (
	// inputs
	input wire core_clk_i,
	input wire resetn_i,
	input wire wdt_reset_i,
	input wire ce_reset_i,
	input wire op_valid_i,
	input wire [3:0] op_code_i,
	input wire [AW-1:0] table_addr_reg_i,
	input wire clock_stop_i,
	input wire [3:0] reg_addr_i,
	input wire reg_rd_i,
	// outputs, and the program word input
	input wire [AW-1:0] prog_addr_o,
	input wire prog_rd_o,
	input wire pc_load_o,
	input wire seg_load_o,
	input wire ar_load_o,
	input wire fetch_buffer_load_o,
	input wire [15:0] fetch_buffer_o,
	input wire [15:0] prog_word_i,
	input wire [7:0] reg_rdata_o
);
	reg busy_ff;
	wire [3:0] c = op_code_i;
	wire go = op_valid_i && !clock_stop_i && !wdt_reset_i && !ce_reset_i;
	wire take = go && !busy_ff;
	// table fetch cycle refuses commands, and stalls while the clock is stopped
	always @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			busy_ff <= 1'b0;
		else
			busy_ff <= (take && c == `RAS_OP_TABLE)
				|| (busy_ff && clock_stop_i && !wdt_reset_i && !ce_reset_i);
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	ret_load_a:
		assert property (take && (c == `RAS_OP_RET || c == `RAS_OP_INTERRUPT_RETURN_INSTR) |=> pc_load_o && !seg_load_o)
		else $error("return did not load counter");
	sysret_load_a:
		assert property (take && c == `RAS_OP_SYSRET |=> pc_load_o && seg_load_o)
		else $error("system return did not load both");
	pop_load_a:
		assert property (take && c == `RAS_OP_POP |=> ar_load_o && !pc_load_o)
		else $error("pop did not load address reg");
	table_seq_a:
		assert property (take && c == `RAS_OP_TABLE |=> prog_rd_o && prog_addr_o == $past(table_addr_reg_i)
			##1 fetch_buffer_load_o && pc_load_o && fetch_buffer_o == prog_word_i)
		else $error("table fetch sequence wrong");
	push_quiet_a:
		assert property (take && c inside {`RAS_OP_CALL, `RAS_OP_INT, `RAS_OP_PUSH, `RAS_OP_SYS}
			|=> !pc_load_o && !ar_load_o && !seg_load_o)
		else $error("save command produced a load");
	stop_hold_a:
		assert property (clock_stop_i && op_valid_i && !busy_ff |=> !pc_load_o && !ar_load_o && !prog_rd_o)
		else $error("command ran during clock stop");
	reset_ptr_a:
		assert property ((wdt_reset_i || ce_reset_i) ##1 (reg_rd_i && reg_addr_i == `RAS_REG_PTR)
			|=> reg_rdata_o == 8'h0f)
		else $error("pointer not all ones in reset");
	idle_quiet_a:
		assert property (!op_valid_i && !busy_ff |=> !(pc_load_o || ar_load_o || fetch_buffer_load_o))
		else $error("load without command");
endmodule
bind ras_return_address_stack ras_checker #(.AW(AW), .SW(SW)) chk_i (
	.core_clk_i(core_clk_i),
	.resetn_i(resetn_i),
	.wdt_reset_i(wdt_reset_i),
	.ce_reset_i(ce_reset_i),
	.op_valid_i(op_valid_i),
	.op_code_i(op_code_i),
	.table_addr_reg_i(table_addr_reg_i),
	.clock_stop_i(clock_stop_i),
	.reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i),
	.prog_addr_o(prog_addr_o),
	.prog_rd_o(prog_rd_o),
	.pc_load_o(pc_load_o),
	.seg_load_o(seg_load_o),
	.ar_load_o(ar_load_o),
	.fetch_buffer_load_o(fetch_buffer_load_o),
	.fetch_buffer_o(fetch_buffer_o),
	.prog_word_i(prog_word_i),
	.reg_rdata_o(reg_rdata_o)
);

// ### sim/ras_return_address_stack_tb.sv
`timescale 1ns/1ns
`include "ras_defs.vh"
module ras_return_address_stack_tb;
	logic clk = 0, rstn = 0, wdt = 0, ce = 0, ov = 0, stop = 0, rw = 0, rr = 0, s;
	logic [3:0] oc = 0, ra = 0, seg = 0;
	logic [13:0] ret = 0, tar = 0;
	logic [7:0] wd = 0;
	logic [17:0] mem [16];
	logic [17:0] v;
	wire [13:0] pa, pcv, arv;
	wire [15:0] pw, fb;
	wire [3:0] sv;
	wire [7:0] rd;
	wire prd, pcl, sgl, arl, fbl, flt, irq;
	int errors = 0, compares = 0, seed = 32'h8f07, sp = 15, c, k;
	always #4 clk = ~clk;
	ras_return_address_stack dut (.core_clk_i(clk), .resetn_i(rstn), .wdt_reset_i(wdt),
		.ce_reset_i(ce), .op_valid_i(ov), .op_code_i(oc), .ret_addr_i(ret), .segment_i(seg),
		.table_addr_reg_i(tar), .clock_stop_i(stop), .prog_word_i(pw), .prog_addr_o(pa),
		.prog_rd_o(prd), .pc_load_o(pcl), .pc_value_o(pcv), .seg_load_o(sgl), .seg_value_o(sv),
		.ar_load_o(arl), .ar_value_o(arv), .fetch_buffer_load_o(fbl), .fetch_buffer_o(fb),
		.stack_fault_reset_o(flt), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(rw),
		.reg_rd_i(rr), .reg_rdata_o(rd), .irq_o(irq));
	ras_pmem_model pm (.addr_i(pa), .word_o(pw));
	function automatic [15:0] pwf(input [13:0] a);
		return {a[1:0], a} ^ 16'h5a3c;
	endfunction
	task chk(input string n, input logic [17:0] e, input logic [17:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input [3:0] a, input [7:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		rw <= 1;
		@(posedge clk);
		rw <= 0;
	endtask
	task rg(input [3:0] a, input [7:0] e);
		@(posedge clk);
		ra <= a;
		rr <= 1;
		@(posedge clk);
		rr <= 0;
		#1 chk("reg", {10'h0, e}, {10'h0, rd});
	endtask
	task op(input [3:0] code, input st);
		@(posedge clk);
		ov <= 1;
		oc <= code;
		stop <= st;
		ret <= $random(seed);
		seg <= $random(seed);
		tar <= $random(seed);
		@(posedge clk);
		ov <= 0;
		stop <= 0;
		#1;
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		errors++;
		results;
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		rg(`RAS_REG_PTR, 8'h0f);
		for (k = 0; k < 300; k++) begin
			c = ($random(seed) & 32'h7fff) % 9 + 1;
			if (sp == 0 && c inside {1, 3, 4, 6, 8}) c = 2;
			if (sp == 15 && c inside {2, 5, 7, 9}) c = 1;
			s = ($random(seed) & 7) == 0;
			op(c[3:0], s);
			if (s) chk("stop", 0, {pcl, arl, prd});
			else if (c inside {1, 4, 6, 8}) begin
				sp--;
				mem[sp] = {c == 6 ? 4'hx : seg, c == 6 ? tar : ret};
				chk("save", 0, {pcl, arl});
			end else if (c == 3) begin
				chk("fetch", {1'b1, tar}, {prd, pa});
				@(posedge clk);
				#1 chk("buffer", {2'b11, pwf(tar)}, {fbl, pcl, fb});
				chk("pc", {4'h0, ret}, {4'h0, pcv});
				@(posedge clk);
			end else begin
				v = sp == 15 ? 18'h0 : mem[sp];
				sp++;
				if (c == 7) chk("ar", {1'b1, v[13:0]}, {arl, arv});
				else chk("pc", {1'b1, v[13:0]}, {pcl, pcv});
				if (c == 9 && v[17:14] !== 4'hx) chk("seg", {1'b1, v[17:14]}, {sgl, sv});
			end
		end
		rg(`RAS_REG_PTR, {4'h0, sp[3:0]});
		for (k = 0; k < 2; k++) begin
			wr(`RAS_REG_PTR, 8'h05);
			wr(`RAS_REG_PTR, 8'h0f);
			rg(`RAS_REG_PTR, 8'h05);
			@(posedge clk);
			if (k == 1) ce <= 1;
			else wdt <= 1;
			@(posedge clk);
			wdt <= 0;
			ce <= 0;
			ra <= `RAS_REG_PTR;
			rr <= 1;
			@(posedge clk);
			rr <= 0;
			#1 chk("reset ptr", 18'h0f, {10'h0, rd});
		end
		wr(`RAS_REG_CTRL, 8'h01);
		wr(`RAS_REG_MASK, 8'h03);
		wr(`RAS_REG_PTR, 8'h00);
		op(`RAS_OP_CALL, 0);
		chk("fault", 1, flt);
		@(posedge clk);
		#1 chk("irq", 1, irq);
		rg(`RAS_REG_STAT, 8'h01);
		wr(`RAS_REG_STAT, 8'h01);
		@(posedge clk);
		#1 chk("irq", 0, irq);
		wr(`RAS_REG_MASK, 8'h00);
		@(posedge clk);
		wdt <= 1;
		@(posedge clk);
		wdt <= 0;
		op(`RAS_OP_POP, 0);
		chk("fault", 1, flt);
		rg(`RAS_REG_STAT, 8'h02);
		chk("irq", 0, irq);
		rg(4'h9, 8'h00);
		results;
	end
endmodule
